/* src/gmcs_defs.svh */
// Offsets, field positions and reset values of the group colour and upper
// group configuration registers. Included by the design files.
`ifndef GMCS_DEFS_SVH
`define GMCS_DEFS_SVH

`define GMCS_ADDR_W 8
`define GMCS_DATA_W 8

// Register offsets
`define GMCS_OFS_RED_MIX 8'hA8
`define GMCS_OFS_GREEN_MIX 8'hA9
`define GMCS_OFS_BLUE_MIX 8'hAA
`define GMCS_OFS_GROUP_CFG 8'hAB

// group_config_upper fields
`define GMCS_TINT_DIS_BIT 4
`define GMCS_TRIPLE_EN_MSB 3
`define GMCS_TRIPLE_EN_LSB 0
`define GMCS_NUM_TRIPLES 4

// Reset values
`define GMCS_MIX_RST 8'h00
`define GMCS_TINT_DIS_RST 1'h0
`define GMCS_TRIPLE_EN_RST 4'h0
`define GMCS_UNMAPPED_RD 8'h00

`endif

/* src/gmcs_pkg.sv */
// Types shared by the group mode and colour select logic.
// Assumes nothing beyond a SystemVerilog compiler.
package gmcs_pkg;

  // Control mode of one triple of LED sinks
  typedef enum logic [1:0]
  {
    GMCS_MODE_MANUAL = 2'h0,
    GMCS_MODE_GROUP = 2'h1,
    GMCS_MODE_BREATH = 2'h2
  } gmcs_mode_e;

endpackage

/* src/gmcs_triple.sv */
// One triple of LED sinks: picks its control mode and its three colour levels.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/1ps
`include "gmcs_defs.svh"

module gmcs_triple
#(
  parameter int DW = `GMCS_DATA_W
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Configuration
  input wire logic i_triple_en,
  input wire logic i_breath_select_bit,
  input wire logic i_shared_tint_disable,
  // Colour sources, red in the low byte
  input wire logic [3*DW-1:0] i_shared_rgb,
  input wire logic [3*DW-1:0] i_own_levels,
  // Results
  output gmcs_pkg::gmcs_mode_e o_mode,
  output logic [3*DW-1:0] o_levels
);

  gmcs_pkg::gmcs_mode_e mode_d;
  logic [3*DW-1:0] levels_d;

  always_comb
  begin
    if (!i_triple_en)
      mode_d = gmcs_pkg::GMCS_MODE_MANUAL;
    else if (i_breath_select_bit)
      mode_d = gmcs_pkg::GMCS_MODE_BREATH;
    else
      mode_d = gmcs_pkg::GMCS_MODE_GROUP;
  end

  // A triple outside group and pattern mode always keeps its own levels
  always_comb
  begin
    if (i_triple_en && !i_shared_tint_disable)
      levels_d = i_shared_rgb;
    else
      levels_d = i_own_levels;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_mode <= gmcs_pkg::GMCS_MODE_MANUAL;
    else
      o_mode <= mode_d;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_levels <= '0;
    else
      o_levels <= levels_d;
  end

endmodule // gmcs_triple

/* src/gmcs_group_cfg.sv */
// Group configuration for LED sinks 25 to 36 and the shared group colour mix.
// Assumes an internal register port fed by the serial-bus slave on the same
// clock, and the breath select bit from the pattern configuration register.
`timescale 1ns/1ps
`include "gmcs_defs.svh"

module gmcs_group_cfg
#(
  parameter int AW = `GMCS_ADDR_W,
  parameter int DW = `GMCS_DATA_W,
  parameter int NT = `GMCS_NUM_TRIPLES
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Register port
  input wire logic [AW-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [DW-1:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [DW-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Pattern configuration held elsewhere
  input wire logic i_breath_select_bit,
  // Per-channel colour levels of sinks 25 to 36, sink 25 in the low byte
  input wire logic [3*NT*DW-1:0] i_chan_level,
  // Configuration views
  output logic [NT-1:0] o_triple_mode_enable,
  output logic o_shared_tint_disable,
  // Per-triple mode and per-channel colour in use
  output gmcs_pkg::gmcs_mode_e o_triple_mode [NT],
  output logic [3*NT*DW-1:0] o_chan_tint
);

  // Stored register fields
  logic [DW-1:0] red_mix_q;
  logic [DW-1:0] green_mix_q;
  logic [DW-1:0] blue_mix_q;
  logic [NT-1:0] triple_en_q;
  logic tint_dis_q;

  // One write strobe per register
  logic red_we;
  logic green_we;
  logic blue_we;
  logic cfg_we;

  // Read word, and the shared mix as one bus
  logic [DW-1:0] rdata_d;
  logic [3*DW-1:0] shared_rgb;

  function automatic logic hit(input logic [AW-1:0] addr, input logic [AW-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Reserved bits of the configuration word always read zero
  function automatic logic [DW-1:0] cfg_word(input logic dis, input logic [NT-1:0] en);
    logic [DW-1:0] word;
    word = '0;
    word[`GMCS_TINT_DIS_BIT] = dis;
    word[`GMCS_TRIPLE_EN_MSB:`GMCS_TRIPLE_EN_LSB] = en;
    cfg_word = word;
  endfunction

  // Exact address decode: a write to any other address is dropped
  always_comb
  begin
    red_we = i_reg_wr && hit(i_reg_addr, `GMCS_OFS_RED_MIX);
    green_we = i_reg_wr && hit(i_reg_addr, `GMCS_OFS_GREEN_MIX);
    blue_we = i_reg_wr && hit(i_reg_addr, `GMCS_OFS_BLUE_MIX);
    cfg_we = i_reg_wr && hit(i_reg_addr, `GMCS_OFS_GROUP_CFG);
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      red_mix_q <= `GMCS_MIX_RST;
    end
    else if (red_we)
    begin
      red_mix_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      green_mix_q <= `GMCS_MIX_RST;
    end
    else if (green_we)
    begin
      green_mix_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      blue_mix_q <= `GMCS_MIX_RST;
    end
    else if (blue_we)
    begin
      blue_mix_q <= i_reg_wdata;
    end
  end

  // Reserved bits 7:5 are not stored, so a write to them has no effect
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      triple_en_q <= `GMCS_TRIPLE_EN_RST;
    end
    else if (cfg_we)
    begin
      triple_en_q <= i_reg_wdata[`GMCS_TRIPLE_EN_MSB:`GMCS_TRIPLE_EN_LSB];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tint_dis_q <= `GMCS_TINT_DIS_RST;
    end
    else if (cfg_we)
    begin
      tint_dis_q <= i_reg_wdata[`GMCS_TINT_DIS_BIT];
    end
  end

  always_comb
  begin
    rdata_d = `GMCS_UNMAPPED_RD;
    case (i_reg_addr)
      `GMCS_OFS_RED_MIX: rdata_d = red_mix_q;
      `GMCS_OFS_GREEN_MIX: rdata_d = green_mix_q;
      `GMCS_OFS_BLUE_MIX: rdata_d = blue_mix_q;
      `GMCS_OFS_GROUP_CFG: rdata_d = cfg_word(tint_dis_q, triple_en_q);
      default: rdata_d = `GMCS_UNMAPPED_RD;
    endcase
  end

  // Read data is held until the next read so the bus slave may sample late
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_reg_rdata <= '0;
    end
    else if (i_reg_rd)
    begin
      o_reg_rdata <= rdata_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_reg_rvalid <= 1'h0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_triple_mode_enable <= '0;
    end
    else
    begin
      o_triple_mode_enable <= triple_en_q;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_shared_tint_disable <= 1'h0;
    end
    else
    begin
      o_shared_tint_disable <= tint_dis_q;
    end
  end

  // Red sits in the low byte, so it lands on the lowest sink of a triple
  assign shared_rgb = {blue_mix_q, green_mix_q, red_mix_q};

  // Each triple reacts directly to the stored bits: no commit write needed
  for (genvar t = 0; t < NT; t++)
  begin : g_triple
    gmcs_triple #(.DW(DW)) gmcs_triple_i
    (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_triple_en(triple_en_q[t]),
      .i_breath_select_bit(i_breath_select_bit),
      .i_shared_tint_disable(tint_dis_q),
      .i_shared_rgb(shared_rgb),
      .i_own_levels(i_chan_level[t*3*DW +: 3*DW]),
      .o_mode(o_triple_mode[t]),
      .o_levels(o_chan_tint[t*3*DW +: 3*DW])
    );
  end

endmodule // gmcs_group_cfg

/* verification/gmcs_host_model.sv */
// Host model: single-cycle write and read strobes on the register port.
// Assumes the block answers a read by the fourth edge after the read strobe rises.
`timescale 1ns/1ps
module gmcs_host_model
(
  // Clock
  input wire logic i_sys_clk,
  // Register port
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_rd,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid
);
  initial {o_reg_addr, o_reg_wr, o_reg_wdata, o_reg_rd} = 18'h0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= 1'h1;
    @(posedge i_sys_clk);
    o_reg_wr <= 1'h0;
    o_reg_wdata <= ~d; // Stale data must not look valid
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge i_sys_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'h1;
    @(posedge i_sys_clk);
    o_reg_rd <= 1'h0;
    ok = 1'h0;
    for (int k = 0; k < 4 && !ok; k++)
    begin
      #1;
      ok = i_reg_rvalid;
      d = i_reg_rdata;
      if (!ok) @(posedge i_sys_clk);
    end
  endtask
endmodule // gmcs_host_model

/* verification/gmcs_group_cfg_sva.sv */
// Port checker for the group config block.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module gmcs_group_cfg_sva
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  // Mode and colour
  input wire logic i_breath_select_bit,
  input wire logic [95:0] i_chan_level,
  input wire logic [3:0] o_triple_mode_enable,
  input wire logic o_shared_tint_disable,
  input wire gmcs_pkg::gmcs_mode_e o_triple_mode [4],
  input wire logic [95:0] o_chan_tint
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  wire cfg_wr = i_reg_wr && i_reg_addr == 8'hAB;
  wire cfg_rd = i_reg_rd && i_reg_addr == 8'hAB;
  wire bad_rd = i_reg_rd && (i_reg_addr < 8'hA8 || i_reg_addr > 8'hAB);
  rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid) else $error("no rvalid");
  stray_rvalid_a: assert property (o_reg_rvalid |-> $past(i_reg_rd)) else $error("stray");
  reserved_zero_a: assert property (cfg_rd |=> o_reg_rdata[7:5] == 3'h0) else $error("resv");
  unmapped_zero_a: assert property (bad_rd |=> o_reg_rdata == 8'h00) else $error("unmap");
  tint_view_a:
    assert property (cfg_wr |-> ##2 o_shared_tint_disable == $past(i_reg_wdata[4], 2))
    else $error("tint view");
  enable_view_a:
    assert property (cfg_wr |-> ##2 o_triple_mode_enable == $past(i_reg_wdata[3:0], 2))
    else $error("enable view");
  triple_mode_a:
    assert property (o_triple_mode[0] == (!o_triple_mode_enable[0] ? gmcs_pkg::GMCS_MODE_MANUAL :
      $past(i_breath_select_bit) ? gmcs_pkg::GMCS_MODE_BREATH : gmcs_pkg::GMCS_MODE_GROUP))
    else $error("mode");
  own_tint_a:
    assert property ($past(i_nrst) && !(o_triple_mode_enable[0] && !o_shared_tint_disable)
      |-> o_chan_tint[7:0] == $past(i_chan_level[7:0])) else $error("own tint");
endmodule // gmcs_group_cfg_sva
bind gmcs_group_cfg gmcs_group_cfg_sva gmcs_group_cfg_sva_i (.*);

/* verification/test_group_mode_color_select.sv */
// Self-checking bench: host model writes and reads, bench checks the views.
// Assumes the 2-cycle write-to-output latency of the block.
`timescale 1ns/1ps
module test_group_mode_color_select;
  logic i_sys_clk, i_nrst, i_reg_wr, i_reg_rd, o_reg_rvalid, ok;
  logic i_breath_select_bit, o_shared_tint_disable;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, got;
  logic [95:0] i_chan_level, o_chan_tint;
  logic [3:0] o_triple_mode_enable;
  gmcs_pkg::gmcs_mode_e o_triple_mode [4];
  int err_total = 0;
  int n_checks = 0;
  gmcs_host_model gmcs_host_model_i (.i_sys_clk, .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
    .o_reg_wdata(i_reg_wdata), .o_reg_rd(i_reg_rd), .i_reg_rdata(o_reg_rdata),
    .i_reg_rvalid(o_reg_rvalid));
  gmcs_group_cfg gmcs_group_cfg_i (.*);
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    gmcs_host_model_i.wr(a, d);
    repeat (2) @(posedge i_sys_clk); // Fixed write-to-view latency
    #1;
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    gmcs_host_model_i.rd(a, got, ok);
    if (ok !== 1'h1)
    begin
      err_total++; // A missing answer ends the run
      print_verdict();
    end
    else
      chk(got, e);
  endtask
  task automatic t_regs;
    r(8'hA8, 8'h00);
    r(8'hAB, 8'h00);
    chk(o_triple_mode_enable, 4'h0);
    chk(o_triple_mode[3], gmcs_pkg::GMCS_MODE_MANUAL);
    w(8'hA8, 8'h11);
    w(8'hA9, 8'h22);
    w(8'hAA, 8'h33);
    w(8'hAB, 8'hFF);
    r(8'hA9, 8'h22);
    r(8'hAA, 8'h33);
    w(8'hAC, 8'h55);
    r(8'hAB, 8'h1F);
    r(8'hAC, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_modes;
    w(8'hAB, 8'h01);
    chk(o_triple_mode[0], gmcs_pkg::GMCS_MODE_GROUP);
    chk(o_triple_mode[1], gmcs_pkg::GMCS_MODE_MANUAL);
    chk(o_shared_tint_disable, 1'h0);
    chk(o_chan_tint[31:0], 32'h53332211);
    @(posedge i_sys_clk);
    i_breath_select_bit <= 1'h1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk(o_triple_mode[0], gmcs_pkg::GMCS_MODE_BREATH);
    w(8'hAB, 8'h18);
    chk(o_triple_mode[3], gmcs_pkg::GMCS_MODE_BREATH);
    chk(o_triple_mode[0], gmcs_pkg::GMCS_MODE_MANUAL);
    chk(o_shared_tint_disable, 1'h1);
    chk(o_chan_tint[95:72], 24'h5B5A59);
    @(posedge i_sys_clk);
    i_breath_select_bit <= 1'h0;
    w(8'hAB, 8'h06);
    chk(o_triple_mode[2], gmcs_pkg::GMCS_MODE_GROUP);
    chk(o_triple_mode[3], gmcs_pkg::GMCS_MODE_MANUAL);
    chk(o_chan_tint, 96'h5B5A59_332211_332211_525150);
    $display("test modes done");
  endtask
  initial
  begin
    i_sys_clk = 1'h0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial
  begin
    i_nrst = 1'h0;
    i_breath_select_bit = 1'h0;
    i_chan_level = 96'h5B5A5958_57565554_53525150;
    repeat (16) @(posedge i_sys_clk);
    i_nrst <= 1'h1;
    t_regs();
    t_modes();
    print_verdict();
  end
endmodule // test_group_mode_color_select
